// ### cra_params.svh
`ifndef CRA_PARAMS_SVH
`define CRA_PARAMS_SVH
`define CRA_ADDR_CTRL   32'h0000_0000
`define CRA_ADDR_CNT0   32'h0000_0004
`define CRA_ADDR_CNT1   32'h0000_0008
`define CRA_ADDR_STATUS 32'h0000_000C
`define CRA_BIT_CH0_EN  0
`define CRA_BIT_LVL0    1
`define CRA_BIT_LVL1    2
`define CRA_BIT_IOHALT  3
`define CRA_CTRL_RST    4'h0
`define CRA_CNT_RST     16'h0000
`define CRA_CNT_DONE    16'h0000
`endif

// ### cra_pkg.sv
package cra_pkg;
    typedef enum logic [2:0] {
        CRA_OWN_CPU,
        CRA_OWN_REFRESH,
        CRA_OWN_DMA,
        CRA_OWN_RELEASE,
        CRA_OWN_IRQACK
    } cra_owner_t;

    typedef struct packed {
        logic bus_hold;
        logic refresh;
        logic dma;
    } cra_mc_req_t;
endpackage : cra_pkg

// ### cra_arbiter.sv
// Added by the designer: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "cra_params.svh"
module cra_arbiter (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        machine_cycle,
    input  wire logic        instr_end,
    input  wire logic        wait_state_slot,
    input  wire logic        wait_request,
    input  wire logic        refresh_request,
    input  wire logic        dma_req_line_ch0,
    input  wire logic        dma_req_line_ch1,
    input  wire logic        bus_hold_request,
    input  wire logic        nmi_n,
    input  wire logic        maskable_irq_line_a,
    input  wire logic        maskable_irq_line_b,
    input  wire logic        maskable_irq_line_c,
    input  wire logic        dma_byte_done,
    output logic             wait_insert,
    output logic             bus_float,
    output logic             bus_ack_n,
    output logic             refresh_grant,
    output logic             dma_grant,
    output logic             irq_accept,
    output logic             cpu_run,
    output logic             io_halt_mode
);
    // Pin synchronisers: first stage read only by second stage
    logic [6:0] sync1_reg;
    logic [6:0] sync2_reg;
    logic [6:0] pins_raw;
    assign pins_raw = {wait_request, dma_req_line_ch0, dma_req_line_ch1, bus_hold_request, nmi_n, 1'b0,
                       maskable_irq_line_a | maskable_irq_line_b | maskable_irq_line_c};
    // Reset to the idle level of every pin so no false edge follows reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_reg <= 7'h34;
            sync2_reg <= 7'h34;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
        end
    end
    logic wait_s, dma_req_line_ch0_n, dma_req_line_ch1_n, hold_s, nmi_s_n, irq_s;
    assign wait_s  = sync2_reg[6];
    assign dma_req_line_ch0_n = sync2_reg[5];
    assign dma_req_line_ch1_n = sync2_reg[4];
    assign hold_s  = sync2_reg[3];
    assign nmi_s_n = sync2_reg[2];
    assign irq_s   = sync2_reg[0];

    // AHB-Lite register slave, zero wait states
    logic [3:0]  ctrl_reg, ctrl_next;
    logic [15:0] cnt0_reg, cnt0_next, cnt1_reg, cnt1_next;
    logic        wr_pend_reg, wr_pend_next;
    logic [31:0] wr_addr_reg, wr_addr_next, hrdata_next;
    logic        ch0_en_clr;
    logic        xfer;
    assign xfer = hsel && hready && htrans[1];

    // Arbiter state
    cra_pkg::cra_owner_t owner_reg, owner_next;
    logic dma_active_reg, dma_active_next;
    logic dma_ch_reg, dma_ch_next;
    logic dma_req_line_ch0_prev_reg, dma_req_line_ch1_prev_reg, edge_pend_reg, edge_pend_next;
    logic wait_reg, wait_next;
    logic irq_pend_reg, irq_pend_next, irq_acc_reg, irq_acc_next;
    cra_pkg::cra_mc_req_t req;

    always_comb begin
        ctrl_next    = ctrl_reg;
        cnt0_next    = cnt0_reg;
        cnt1_next    = cnt1_reg;
        wr_pend_next = xfer && hwrite;
        wr_addr_next = xfer ? haddr : wr_addr_reg;
        hrdata_next  = 32'h0000_0000;
        if (wr_pend_reg) begin
            case (wr_addr_reg)
                `CRA_ADDR_CTRL: ctrl_next = hwdata[3:0];
                `CRA_ADDR_CNT0: cnt0_next = hwdata[15:0];
                `CRA_ADDR_CNT1: cnt1_next = hwdata[15:0];
                default:        ;
            endcase
        end
        if (dma_active_reg && dma_byte_done && owner_reg == cra_pkg::CRA_OWN_DMA) begin
            if (!dma_ch_reg && cnt0_reg != `CRA_CNT_DONE) cnt0_next = cnt0_reg - 16'h0001;
            if (dma_ch_reg && cnt1_reg != `CRA_CNT_DONE)  cnt1_next = cnt1_reg - 16'h0001;
        end
        // Hardware clear of the enable loses to nothing except a same-cycle software write to the CTRL address
        if (ch0_en_clr && !(wr_pend_reg && wr_addr_reg == `CRA_ADDR_CTRL)) ctrl_next[`CRA_BIT_CH0_EN] = 1'b0;
        if (xfer && !hwrite) begin
            case (haddr)
                `CRA_ADDR_CTRL:   hrdata_next = {28'h000_0000, ctrl_reg};
                `CRA_ADDR_CNT0:   hrdata_next = {16'h0000, cnt0_reg};
                `CRA_ADDR_CNT1:   hrdata_next = {16'h0000, cnt1_reg};
                `CRA_ADDR_STATUS: hrdata_next = {24'h00_0000, dma_ch_reg, dma_active_reg, irq_pend_reg,
                                                 wait_reg, 1'b0, owner_reg};
                default:          hrdata_next = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg    <= `CRA_CTRL_RST;
            cnt0_reg    <= `CRA_CNT_RST;
            cnt1_reg    <= `CRA_CNT_RST;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 32'h0000_0000;
            hrdata      <= 32'h0000_0000;
        end else begin
            ctrl_reg    <= ctrl_next;
            cnt0_reg    <= cnt0_next;
            cnt1_reg    <= cnt1_next;
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata      <= hrdata_next;
        end
    end
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Request decode
    logic lvl0, lvl1, in_release, dma_req_line_ch0_ok, dma_req_line_ch1_ok, dma_want, dma_stop;
    assign lvl0       = ctrl_reg[`CRA_BIT_LVL0];
    assign lvl1       = ctrl_reg[`CRA_BIT_LVL1];
    assign in_release = owner_reg == cra_pkg::CRA_OWN_RELEASE;
    // Level lines are refused while released; falling edges are remembered instead
    assign dma_req_line_ch0_ok = lvl0 ? (!dma_req_line_ch0_n && !in_release) : (dma_req_line_ch0_prev_reg && !dma_req_line_ch0_n);
    assign dma_req_line_ch1_ok = lvl1 ? (!dma_req_line_ch1_n && !in_release) : (dma_req_line_ch1_prev_reg && !dma_req_line_ch1_n);
    assign dma_want = dma_req_line_ch0_ok || dma_req_line_ch1_ok || ctrl_reg[`CRA_BIT_CH0_EN] || edge_pend_reg;
    // Stop on line high in level mode (channel 0 only with its enable clear), count exhausted or NMI low
    assign dma_stop = dma_active_reg && (!nmi_s_n ||
                      (dma_ch_reg ? (cnt1_reg == `CRA_CNT_DONE || (!lvl1 ? 1'b0 : dma_req_line_ch1_n))
                                  : (cnt0_reg == `CRA_CNT_DONE ||
                                     (!ctrl_reg[`CRA_BIT_CH0_EN] && lvl0 && dma_req_line_ch0_n))));
    assign ch0_en_clr = dma_stop && !dma_ch_reg;
    assign req.bus_hold = hold_s;
    assign req.refresh  = refresh_request && !hold_s;
    assign req.dma      = (dma_want || dma_active_reg) && !dma_stop;

    always_comb begin
        owner_next      = owner_reg;
        dma_active_next = dma_stop ? 1'b0 : dma_active_reg;
        dma_ch_next     = dma_ch_reg;
        edge_pend_next  = edge_pend_reg;
        irq_pend_next   = irq_pend_reg || irq_s;
        irq_acc_next    = 1'b0;
        // Wait is only looked at in its designated slot and never during refresh or release
        wait_next = wait_reg;
        if (wait_state_slot) wait_next = wait_s && owner_reg != cra_pkg::CRA_OWN_REFRESH && !in_release;
        // The owner does not change while a wait is inserted; a DMA stop still clears dma_active_reg
        if (machine_cycle && !wait_reg) begin
            if (req.bus_hold) begin
                owner_next = cra_pkg::CRA_OWN_RELEASE;
            end else if (req.refresh && owner_reg != cra_pkg::CRA_OWN_REFRESH) begin
                owner_next = cra_pkg::CRA_OWN_REFRESH;
            end else if (req.dma && !in_release) begin
                owner_next      = cra_pkg::CRA_OWN_DMA;
                edge_pend_next  = 1'b0;
                if (!dma_active_reg) begin
                    dma_active_next = 1'b1;
                    dma_ch_next     = !(dma_req_line_ch0_ok || ctrl_reg[`CRA_BIT_CH0_EN]) && dma_req_line_ch1_ok;
                end
            end else if (irq_pend_reg && instr_end && !dma_active_reg) begin
                owner_next    = cra_pkg::CRA_OWN_IRQACK;
                irq_pend_next = irq_s;
                irq_acc_next  = 1'b1;
            end else begin
                owner_next = cra_pkg::CRA_OWN_CPU;
            end
        end
        // A falling edge is kept until granted; a new edge beats the grant clear
        if (!lvl0 && dma_req_line_ch0_prev_reg && !dma_req_line_ch0_n) edge_pend_next = 1'b1;
        if (!lvl1 && dma_req_line_ch1_prev_reg && !dma_req_line_ch1_n) edge_pend_next = 1'b1;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            owner_reg      <= cra_pkg::CRA_OWN_CPU;
            dma_active_reg <= 1'b0;
            dma_ch_reg     <= 1'b0;
            dma_req_line_ch0_prev_reg <= 1'b1;
            dma_req_line_ch1_prev_reg <= 1'b1;
            edge_pend_reg  <= 1'b0;
            wait_reg       <= 1'b0;
            irq_pend_reg   <= 1'b0;
            irq_acc_reg    <= 1'b0;
        end else begin
            owner_reg      <= owner_next;
            dma_active_reg <= dma_active_next;
            dma_ch_reg     <= dma_ch_next;
            dma_req_line_ch0_prev_reg <= dma_req_line_ch0_n;
            dma_req_line_ch1_prev_reg <= dma_req_line_ch1_n;
            edge_pend_reg  <= edge_pend_next;
            wait_reg       <= wait_next;
            irq_pend_reg   <= irq_pend_next;
            irq_acc_reg    <= irq_acc_next;
        end
    end

    // Registered outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_insert   <= 1'b0;
            bus_float     <= 1'b0;
            bus_ack_n     <= 1'b1;
            refresh_grant <= 1'b0;
            dma_grant     <= 1'b0;
            irq_accept    <= 1'b0;
            cpu_run       <= 1'b1;
            io_halt_mode  <= 1'b0;
        end else begin
            wait_insert   <= wait_next;
            bus_float     <= owner_next == cra_pkg::CRA_OWN_RELEASE;
            bus_ack_n     <= owner_next != cra_pkg::CRA_OWN_RELEASE;
            refresh_grant <= owner_next == cra_pkg::CRA_OWN_REFRESH;
            dma_grant     <= owner_next == cra_pkg::CRA_OWN_DMA;
            irq_accept    <= irq_acc_next;
            cpu_run       <= owner_next == cra_pkg::CRA_OWN_CPU || owner_next == cra_pkg::CRA_OWN_IRQACK;
            io_halt_mode  <= ctrl_reg[`CRA_BIT_IOHALT];
        end
    end

    // Assertions
    property p_one_owner;
        @(posedge hclk) disable iff (!hresetn)
        $onehot0({bus_float, refresh_grant, dma_grant}) && !(cpu_run && (bus_float || dma_grant));
    endproperty
    a_one_owner: assert property (p_one_owner) else $error("more than one bus owner");
    property p_hold_first;
        @(posedge hclk) disable iff (!hresetn)
        machine_cycle && !wait_reg && hold_s |=> bus_float && !refresh_grant;
    endproperty
    a_hold_first: assert property (p_hold_first) else $error("bus hold not granted first");
    property p_hold_kills_refresh;
        @(posedge hclk) disable iff (!hresetn)
        machine_cycle && !wait_reg && hold_s && refresh_request |=> !refresh_grant;
    endproperty
    a_hold_kills_refresh: assert property (p_hold_kills_refresh) else $error("refresh not discarded");
    property p_owner_stable;
        @(posedge hclk) disable iff (!hresetn)
        !machine_cycle |=> $stable(owner_reg);
    endproperty
    a_owner_stable: assert property (p_owner_stable) else $error("owner changed mid cycle");
    property p_wait_holds;
        @(posedge hclk) disable iff (!hresetn)
        wait_reg && !wait_state_slot |=> $stable(owner_reg) && wait_insert;
    endproperty
    a_wait_holds: assert property (p_wait_holds) else $error("wait did not freeze arbitration");
    property p_wait_slot;
        @(posedge hclk) disable iff (!hresetn)
        !wait_state_slot |=> $stable(wait_reg);
    endproperty
    a_wait_slot: assert property (p_wait_slot) else $error("wait sampled outside slot");
    property p_irq_at_end;
        @(posedge hclk) disable iff (!hresetn)
        irq_acc_next |-> instr_end && machine_cycle && !hold_s;
    endproperty
    a_irq_at_end: assert property (p_irq_at_end) else $error("interrupt accepted mid instruction");
    property p_nmi_stops;
        @(posedge hclk) disable iff (!hresetn)
        dma_active_reg && !nmi_s_n |=> !dma_active_reg;
    endproperty
    a_nmi_stops: assert property (p_nmi_stops) else $error("NMI did not end DMA");
    property p_lvl_refused;
        @(posedge hclk) disable iff (!hresetn)
        in_release && machine_cycle && !wait_reg && !hold_s |=> !dma_grant;
    endproperty
    a_lvl_refused: assert property (p_lvl_refused) else $error("DMA right after release");
    property p_cpu_idle;
        @(posedge hclk) disable iff (!hresetn)
        machine_cycle && !wait_reg && !hold_s && !refresh_request && !(req.dma && !in_release) && !instr_end |=> cpu_run;
    endproperty
    a_cpu_idle: assert property (p_cpu_idle) else $error("processor not running when idle");
    property p_mem_start;
        @(posedge hclk) disable iff (!hresetn)
        machine_cycle && !wait_reg && !hold_s && !refresh_request && !in_release && req.dma |=> dma_grant;
    endproperty
    a_mem_start: assert property (p_mem_start) else $error("DMA request not granted");
    property p_edge_kept;
        @(posedge hclk) disable iff (!hresetn)
        !lvl0 && dma_req_line_ch0_prev_reg && !dma_req_line_ch0_n |=> edge_pend_reg;
    endproperty
    a_edge_kept: assert property (p_edge_kept) else $error("edge request lost");
    c_release: cover property (@(posedge hclk) disable iff (!hresetn) $rose(bus_float));
    c_edge:    cover property (@(posedge hclk) disable iff (!hresetn) edge_pend_reg ##1 dma_grant);
    c_dma:     cover property (@(posedge hclk) disable iff (!hresetn) $fell(dma_active_reg));
    c_irq:     cover property (@(posedge hclk) disable iff (!hresetn) irq_accept);
    c_refresh: cover property (@(posedge hclk) disable iff (!hresetn) refresh_grant ##1 dma_grant);
endmodule : cra_arbiter

// ### cra_far_end.sv
`timescale 1ns/1ps
module cra_far_end (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       slow,
    input  wire logic [6:0] want,
    output logic            bus_hold_request,
    output logic            dma_req_line_ch0,
    output logic            dma_req_line_ch1,
    output logic [2:0]      irq,
    output logic            nmi_n
);
    logic [6:0] stage_reg;
    logic [6:0] live;
    // A slow far end reacts one clock late, like a peripheral behind its own flop
    assign live = slow ? stage_reg : want;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage_reg <= 7'h00;
        end else begin
            stage_reg <= want;
        end
    end
    assign bus_hold_request = live[0];
    assign dma_req_line_ch0 = ~live[1];
    assign dma_req_line_ch1 = ~live[2];
    assign irq              = live[5:3];
    assign nmi_n            = ~live[6];
endmodule : cra_far_end

// ### cra_arbiter_bench.sv
`timescale 1ns/1ps
module cra_arbiter_bench;
    logic        hclk, hresetn, hsel, hwrite, machine_cycle, instr_end, wait_state_slot;
    logic        wait_request, refresh_request, dma_byte_done, slow, slot_en, byte_en, hit;
    logic [31:0] haddr, hwdata, hrdata, rd, r;
    logic [1:0]  htrans, mc_cnt;
    logic [2:0]  hsize, irq;
    logic [6:0]  want;
    logic        hreadyout, hresp, wait_insert, bus_float, bus_ack_n, refresh_grant, dma_grant;
    logic        irq_accept, cpu_run, io_halt_mode, bus_hold_request, dma_req_line_ch0;
    logic        dma_req_line_ch1, nmi_n;
    int          n_fail, n_compared, cyc, f;
    logic [31:0] f_addr [4] = '{32'h0000_0000, 32'h0000_0008, 32'h0000_000c, 32'h0000_0010};
    wire  [6:0]  obs = {cpu_run, irq_accept, dma_grant, refresh_grant, ~bus_ack_n, bus_float, wait_insert};

    cra_arbiter u_cra_arbiter (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .machine_cycle(machine_cycle),
        .instr_end(instr_end), .wait_state_slot(wait_state_slot), .wait_request(wait_request),
        .refresh_request(refresh_request), .dma_req_line_ch0(dma_req_line_ch0),
        .dma_req_line_ch1(dma_req_line_ch1), .bus_hold_request(bus_hold_request), .nmi_n(nmi_n),
        .maskable_irq_line_a(irq[0]), .maskable_irq_line_b(irq[1]), .maskable_irq_line_c(irq[2]),
        .dma_byte_done(dma_byte_done), .wait_insert(wait_insert), .bus_float(bus_float),
        .bus_ack_n(bus_ack_n), .refresh_grant(refresh_grant), .dma_grant(dma_grant),
        .irq_accept(irq_accept), .cpu_run(cpu_run), .io_halt_mode(io_halt_mode));

    cra_far_end u_cra_far_end (.hclk(hclk), .hresetn(hresetn), .slow(slow), .want(want),
        .bus_hold_request(bus_hold_request), .dma_req_line_ch0(dma_req_line_ch0),
        .dma_req_line_ch1(dma_req_line_ch1), .irq(irq), .nmi_n(nmi_n));

    always #10 hclk = ~hclk;

    // Machine cycles of three clocks; the wait slot sits in the middle state
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        mc_cnt <= (mc_cnt == 2'h2) ? 2'h0 : mc_cnt + 2'h1;
        machine_cycle <= (mc_cnt == 2'h1);
        wait_state_slot <= slot_en && (mc_cnt == 2'h0);
        dma_byte_done <= byte_en && dma_grant && (mc_cnt == 2'h1);
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Single word transfer; hready is sampled at each rising edge before moving on
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        logic rdy;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do begin
            @(posedge hclk);
            rdy = hreadyout;
        end while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin
            @(posedge hclk);
            rdy = hreadyout;
            rd = hrdata;
        end while (rdy !== 1'b1);
    endtask : ahb

    task automatic await(input int k, input logic v, input int lim);
        hit = 1'b0;
        repeat (lim) begin
            @(negedge hclk);
            if (obs[k] === v) begin
                hit = 1'b1;
                break;
            end
        end
    endtask : await

    // Which of two outputs shows up first, -1 if neither
    task automatic race(input int ka, input int kb);
        f = -1;
        repeat (60) begin
            @(negedge hclk);
            if (obs[ka] === 1'b1 || obs[kb] === 1'b1) begin
                f = (obs[ka] === 1'b1) ? ka : kb;
                break;
            end
        end
    endtask : race

    task automatic end_of_test;
        $display("compared %0d mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        {hclk, hresetn, hsel, hwrite, machine_cycle, instr_end, wait_state_slot} = 7'h00;
        {wait_request, refresh_request, dma_byte_done, slow, slot_en, byte_en} = 6'h00;
        {haddr, hwdata, htrans, mc_cnt, want, cyc, n_fail, n_compared} = '0;
        hsize = 3'b010;
        r = $urandom(32'h3c03_cbfc);
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk("idle outputs", 32'({hresp, obs}), 32'h0000_0040);
        foreach (f_addr[i]) begin
            ahb(1'b0, f_addr[i], 32'h0000_0000);
            chk("reset value", rd, 32'h0000_0000);
        end
        r = $urandom;
        ahb(1'b1, 32'h0000_0004, r);
        ahb(1'b1, 32'h0000_0010, 32'hffff_ffff);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("count0", rd, {16'h0000, r[15:0]});
        ahb(1'b0, 32'h0000_0010, 32'h0000_0000);
        chk("unmapped", rd, 32'h0000_0000);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0008);
        repeat (2) @(negedge hclk);
        chk("io halt", 32'(io_halt_mode), 32'h0000_0001);
        $display("test registers done");
        wait_request <= 1'b1;
        await(0, 1'b1, 15);
        chk("wait outside slot", 32'(hit), 32'h0000_0000);
        slot_en <= 1'b1;
        await(0, 1'b1, 40);
        chk("wait in slot", 32'(hit), 32'h0000_0001);
        want <= 7'h01;
        await(1, 1'b1, 15);
        chk("hold under wait", 32'(hit), 32'h0000_0000);
        wait_request <= 1'b0;
        await(1, 1'b1, 40);
        chk("bus floated", 32'(hit), 32'h0000_0001);
        $display("test wait done");
        ahb(1'b1, 32'h0000_0000, 32'h0000_0002);
        want <= 7'h03;
        refresh_request <= 1'b1;
        await(4, 1'b1, 20);
        chk("level dma in release", 32'(hit), 32'h0000_0000);
        await(3, 1'b1, 10);
        chk("refresh in release", 32'(hit), 32'h0000_0000);
        refresh_request <= 1'b0;
        want <= 7'h02;
        await(2, 1'b0, 40);
        chk("release ends", 32'(hit), 32'h0000_0001);
        await(4, 1'b1, 40);
        chk("level dma after", 32'(hit), 32'h0000_0001);
        want <= 7'h00;
        await(4, 1'b0, 40);
        chk("line high ends dma", 32'(hit), 32'h0000_0001);
        $display("test release done");
        @(posedge hclk iff machine_cycle);
        want <= 7'h01;
        @(posedge hclk);
        refresh_request <= 1'b1;
        race(1, 3);
        chk("hold beats refresh", 32'(f), 32'h0000_0001);
        want <= 7'h00;
        refresh_request <= 1'b0;
        await(3, 1'b1, 30);
        chk("refresh dropped", 32'(hit), 32'h0000_0000);
        $display("test hold refresh done");
        ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
        ahb(1'b1, 32'h0000_0004, 32'h0000_0002);
        byte_en <= 1'b1;
        @(posedge hclk iff machine_cycle);
        want <= 7'h02;
        @(posedge hclk);
        refresh_request <= 1'b1;
        race(3, 4);
        chk("refresh beats dma", 32'(f), 32'h0000_0003);
        refresh_request <= 1'b0;
        await(4, 1'b1, 40);
        chk("dma follows", 32'(hit), 32'h0000_0001);
        want <= 7'h00;
        await(4, 1'b0, 200);
        chk("count ends dma", 32'(hit), 32'h0000_0001);
        $display("test priority done");
        r = ($urandom % 4) + 1;
        ahb(1'b1, 32'h0000_0004, r);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
        await(4, 1'b1, 40);
        chk("mem dma starts", 32'(hit), 32'h0000_0001);
        await(4, 1'b0, 300);
        chk("mem dma ends", 32'(hit), 32'h0000_0001);
        ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
        chk("count at zero", rd, 32'h0000_0000);
        ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
        chk("enable cleared", rd, 32'h0000_0000);
        byte_en <= 1'b0;
        ahb(1'b1, 32'h0000_0004, 32'h0000_00ff);
        ahb(1'b1, 32'h0000_0000, 32'h0000_0001);
        await(4, 1'b1, 40);
        want <= 7'h40;
        await(4, 1'b0, 20);
        chk("nmi ends dma", 32'(hit), 32'h0000_0001);
        want <= 7'h00;
        $display("test dma done");
        ahb(1'b1, 32'h0000_0000, 32'h0000_0000);
        want <= 7'h08;
        await(5, 1'b1, 20);
        chk("irq mid instr", 32'(hit), 32'h0000_0000);
        instr_end <= 1'b1;
        await(5, 1'b1, 40);
        chk("irq at end", 32'(hit), 32'h0000_0001);
        want <= 7'h00;
        $display("test irq done");
        repeat (300) begin
            @(posedge hclk);
            want <= 7'($urandom) & 7'h3f;
            slow <= 1'($urandom);
            refresh_request <= 1'($urandom);
            instr_end <= 1'($urandom);
            @(negedge hclk);
            chk("one owner", 32'($countones({bus_float, refresh_grant, dma_grant}) <= 1), 32'h0000_0001);
        end
        $display("test random done");
        end_of_test();
    end

endmodule : cra_arbiter_bench
